//--- shared/dcw_pkg.sv
package dcw_pkg;
    // Register byte offsets
    localparam logic [11:0] OFS_CONTROL = 12'h000;
    localparam logic [11:0] OFS_SRC_END = 12'h004;
    localparam logic [11:0] OFS_DST_END = 12'h008;
    localparam logic [11:0] OFS_REMAIN = 12'h00C;
    localparam logic [11:0] OFS_SRC_ADDR = 12'h010;
    localparam logic [11:0] OFS_DST_ADDR = 12'h014;
    localparam logic [11:0] OFS_ATTR = 12'h018;

    // Control word field positions
    localparam int DST_INC_LSB = 30;
    localparam int DST_SIZE_LSB = 28;
    localparam int SRC_INC_LSB = 26;
    localparam int SRC_SIZE_LSB = 24;
    localparam int DST_PROT_LSB = 21;

    // Reset values
    localparam logic [31:0] CONTROL_RST = 32'h0000_0000;
    localparam logic [31:0] PTR_RST = 32'h0000_0000;
    localparam logic [9:0] REMAIN_RST = 10'h000;

    // Size and increment encodings
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;
    localparam logic [1:0] INC_FIXED = 2'h3;

    // Bus attribute constants
    localparam logic HPROT_DATA = 1'b1;
    localparam logic [2:0] HSIZE_HI = 3'h0;
endpackage : dcw_pkg

//--- shared/dcw_addr_if.sv
`timescale 1ns/1ns
interface dcw_addr_if;
    logic [31:0] end_ptr;
    logic [1:0] inc;
    logic [9:0] remaining;
    logic [31:0] addr;

    modport ctrl (
        output end_ptr,
        output inc,
        output remaining,
        input addr
    );
    modport gen (
        input end_ptr,
        input inc,
        input remaining,
        output addr
    );
endinterface : dcw_addr_if

//--- rtl/dcw_addr_gen.sv
`timescale 1ns/1ns
module dcw_addr_gen (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Pointer, step and count in, address out
    dcw_addr_if.gen ag
);
    logic [31:0] addr_q;
    logic [31:0] addr_d;
    logic [31:0] offset;

    // Pointer marks the last item, so step back from the end
    always_comb begin
        offset = {22'h000000, ag.remaining} << ag.inc;
        if (ag.inc == dcw_pkg::INC_FIXED) begin
            addr_d = ag.end_ptr;
        end else begin
            addr_d = ag.end_ptr - offset;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_q <= dcw_pkg::PTR_RST;
        end else begin
            addr_q <= addr_d;
        end
    end

    assign ag.addr = addr_q;

    AST_LAST_AT_END: assert property (@(posedge pclk) disable iff (!presetn)
        (ag.remaining == 10'h000) |=> (addr_q == $past(ag.end_ptr)))
        else $error("Last transfer address differs from end pointer");
endmodule : dcw_addr_gen

//--- rtl/dcw_top.sv
`timescale 1ns/1ns
// What this block does
// - Source size bits 25:24 decode as byte, halfword, word; 11 reserved.
// - Source increment bits 27:26 pick byte, halfword or word step.
// - Source increment 11 holds source address at the source end pointer.
// - Destination increment bits 31:30 pick step; no narrower than data width, though a narrower step is not checked.
// - Destination increment 11 holds destination address at its end pointer.
// - Control bits 23:21 drive write protection bits 3:1 on destination writes.
// - Pointers are end addresses; each address steps back from the end.
module dcw_top (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Decoded transfer attributes
    output logic [31:0] src_haddr,
    output logic [31:0] dst_haddr,
    output logic [2:0] src_hsize,
    output logic [2:0] dst_hsize,
    output logic [3:0] dst_hprot
);
    logic [31:0] control_q;
    logic [31:0] src_end_q;
    logic [31:0] dst_end_q;
    logic [9:0] remain_q;
    logic [31:0] prdata_q;
    logic [31:0] rd_d;
    logic [2:0] hsize_q;
    logic [3:0] hprot_q;
    logic hit;
    logic wr_en;
    logic [1:0] src_size;
    logic [1:0] src_inc;
    logic [1:0] dst_inc;

    dcw_addr_if src_if ();
    dcw_addr_if dst_if ();

    assign src_size = control_q[dcw_pkg::SRC_SIZE_LSB +: 2];
    assign src_inc = control_q[dcw_pkg::SRC_INC_LSB +: 2];
    assign dst_inc = control_q[dcw_pkg::DST_INC_LSB +: 2];

    // Address decode
    always_comb begin
        hit = 1'b1;
        rd_d = 32'h0000_0000;
        unique case (paddr)
            dcw_pkg::OFS_CONTROL: begin
                rd_d = control_q;
            end
            dcw_pkg::OFS_SRC_END: begin
                rd_d = src_end_q;
            end
            dcw_pkg::OFS_DST_END: begin
                rd_d = dst_end_q;
            end
            dcw_pkg::OFS_REMAIN: begin
                rd_d = {22'h000000, remain_q};
            end
            dcw_pkg::OFS_SRC_ADDR: begin
                rd_d = src_if.addr;
            end
            dcw_pkg::OFS_DST_ADDR: begin
                rd_d = dst_if.addr;
            end
            dcw_pkg::OFS_ATTR: begin
                rd_d = {25'h0000000, hprot_q, hsize_q};
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    // Zero wait states; read data captured in the setup cycle
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit;
    assign wr_en = psel & penable & pwrite & hit;
    assign prdata = prdata_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdata_q <= rd_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_q <= dcw_pkg::CONTROL_RST;
            src_end_q <= dcw_pkg::PTR_RST;
            dst_end_q <= dcw_pkg::PTR_RST;
            remain_q <= dcw_pkg::REMAIN_RST;
        end else if (wr_en) begin
            unique case (paddr)
                dcw_pkg::OFS_CONTROL: begin
                    control_q <= pwdata;
                end
                dcw_pkg::OFS_SRC_END: begin
                    src_end_q <= pwdata;
                end
                dcw_pkg::OFS_DST_END: begin
                    dst_end_q <= pwdata;
                end
                dcw_pkg::OFS_REMAIN: begin
                    remain_q <= pwdata[9:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Destination width follows source width, so the destination size field is not read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hsize_q <= 3'h0;
            hprot_q <= {3'h0, dcw_pkg::HPROT_DATA};
        end else begin
            hsize_q <= {dcw_pkg::HSIZE_HI[0], src_size};
            hprot_q <= {control_q[dcw_pkg::DST_PROT_LSB +: 3], dcw_pkg::HPROT_DATA};
        end
    end

    // Reserved codes pass through unchecked
    assign src_if.end_ptr = src_end_q;
    assign src_if.inc = src_inc;
    assign src_if.remaining = remain_q;
    assign dst_if.end_ptr = dst_end_q;
    assign dst_if.inc = dst_inc;
    assign dst_if.remaining = remain_q;

    dcw_addr_gen u_src_gen (
        .pclk(pclk),
        .presetn(presetn),
        .ag(src_if.gen)
    );

    dcw_addr_gen u_dst_gen (
        .pclk(pclk),
        .presetn(presetn),
        .ag(dst_if.gen)
    );

    assign src_haddr = src_if.addr;
    assign dst_haddr = dst_if.addr;
    assign src_hsize = hsize_q;
    assign dst_hsize = hsize_q;
    assign dst_hprot = hprot_q;

    AST_SIZE_DECODE: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && pwrite && paddr == dcw_pkg::OFS_CONTROL) ##1 1'b1
        |=> (src_hsize == {1'b0, $past(pwdata[25:24], 2)}))
        else $error("Source size not decoded from written control word");

    AST_SRC_STEP: assert property (@(posedge pclk) disable iff (!presetn)
        (src_inc != 2'h3) |=> (src_haddr == $past(src_end_q) - ({22'h000000, $past(remain_q)} << $past(src_inc))))
        else $error("Source address step wrong");

    AST_SRC_FIXED: assert property (@(posedge pclk) disable iff (!presetn)
        (src_inc == 2'h3) ##1 (src_inc == 2'h3) |-> (src_haddr == src_end_q || $changed(src_end_q)))
        else $error("Fixed source address moved");

    AST_DST_STEP: assert property (@(posedge pclk) disable iff (!presetn)
        (dst_inc != 2'h3) |=> (dst_haddr == $past(dst_end_q) - ({22'h000000, $past(remain_q)} << $past(dst_inc))))
        else $error("Destination address step wrong");

    AST_DST_FIXED: assert property (@(posedge pclk) disable iff (!presetn)
        (dst_inc == 2'h3) |=> (dst_haddr == $past(dst_end_q)))
        else $error("Fixed destination address moved");

    AST_PROT_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && pwrite && paddr == dcw_pkg::OFS_CONTROL) ##1 1'b1
        |=> (dst_hprot == {$past(pwdata[23:21], 2), 1'b1}))
        else $error("Destination protection bits do not follow control word");

    AST_DST_WIDTH: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> (dst_hsize == {1'b0, $past(control_q[dcw_pkg::SRC_SIZE_LSB +: 2])}))
        else $error("Destination size does not follow source size field");

    AST_SRC_HSIZE: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> (src_hsize == {1'b0, $past(control_q[dcw_pkg::SRC_SIZE_LSB +: 2])}))
        else $error("Source size does not follow stored control word");

    AST_CTRL_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && pwrite && paddr == dcw_pkg::OFS_CONTROL) |=> (control_q == $past(pwdata)))
        else $error("Control word write lost");

    AST_RD_CONTROL: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && paddr == dcw_pkg::OFS_CONTROL) |=> (prdata == $past(control_q)))
        else $error("Control word read data wrong");

    AST_SRC_END_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && pwrite && paddr == dcw_pkg::OFS_SRC_END) |=> (src_end_q == $past(pwdata)))
        else $error("Source end pointer write lost");

    AST_DST_END_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && pwrite && paddr == dcw_pkg::OFS_DST_END) |=> (dst_end_q == $past(pwdata)))
        else $error("Destination end pointer write lost");

    AST_REMAIN_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && pwrite && paddr == dcw_pkg::OFS_REMAIN) |=> (remain_q == $past(pwdata[9:0])))
        else $error("Remaining count write lost");

    // Read-only offsets must not disturb the writable words
    AST_RO_IGNORED: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && pwrite && paddr >= dcw_pkg::OFS_SRC_ADDR && paddr <= dcw_pkg::OFS_ATTR)
        |=> ($stable(control_q) && $stable(src_end_q) && $stable(dst_end_q) && $stable(remain_q)))
        else $error("Write to read-only offset changed a register");

    AST_DST_FIXED_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        (dst_inc == dcw_pkg::INC_FIXED) ##1 (dst_inc == dcw_pkg::INC_FIXED && $stable(dst_end_q))
        |=> $stable(dst_haddr))
        else $error("Fixed destination address did not hold");
endmodule : dcw_top

//--- tb/dcw_ahb_slave_model.sv
`timescale 1ns/1ns
module dcw_ahb_slave_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Destination write address phase
    input wire logic [31:0] haddr,
    input wire logic [3:0] hprot,
    // Last accepted attributes
    output logic [31:0] seen_addr,
    output logic [3:0] seen_prot
);
    // Zero wait states, so every address phase is taken
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seen_addr <= 32'h0000_0000;
            seen_prot <= 4'h0;
        end else begin
            seen_addr <= haddr;
            seen_prot <= hprot;
        end
    end
endmodule : dcw_ahb_slave_model

//--- tb/tb.sv
`timescale 1ns/1ns
module tb;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, src_haddr, dst_haddr, seen_addr, rd, cw, ea, eb;
    logic pready, pslverr, er;
    logic [2:0] src_hsize, dst_hsize;
    logic [3:0] dst_hprot, seen_prot;
    logic [1:0] di;
    int miscompares = 0;
    int checks_done = 0;
    int cycles = 0;
    always #5 pclk = ~pclk;
    dcw_top i_dcw_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .src_haddr(src_haddr), .dst_haddr(dst_haddr), .src_hsize(src_hsize), .dst_hsize(dst_hsize),
        .dst_hprot(dst_hprot));
    dcw_ahb_slave_model i_dcw_ahb_slave_model (.pclk(pclk), .presetn(presetn), .haddr(dst_haddr),
        .hprot(dst_hprot), .seen_addr(seen_addr), .seen_prot(seen_prot));
    task automatic give_verdict();
        if (miscompares == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            give_verdict();
        end
    end
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'h1;
        chk({28'h0, dst_hprot}, 32'h1);
        apb(1'h0, dcw_pkg::OFS_CONTROL, 32'h0);
        chk(rd, dcw_pkg::CONTROL_RST);
        chk({31'h0, pready}, 32'h1);
        apb(1'h1, dcw_pkg::OFS_SRC_END, 32'h0000_1000);
        apb(1'h1, dcw_pkg::OFS_DST_END, 32'h0000_2000);
        apb(1'h1, dcw_pkg::OFS_REMAIN, 32'h3);
        // Only legal size and step pairs; software keeps both sizes equal
        for (int s = 0; s < 3; s++) begin
            for (int i = s; i < 4; i++) begin
                di = (i == 3) ? 2'(s) : 2'h3;
                cw = {di, 2'(s), 2'(i), 2'(s), 3'(7 - s * 3 - i), 21'h0};
                ea = (i == 3) ? 32'h1000 : 32'h1000 - (32'h3 << i);
                eb = (di == 2'h3) ? 32'h2000 : 32'h2000 - (32'h3 << di);
                apb(1'h1, dcw_pkg::OFS_CONTROL, cw);
                @(posedge pclk);
                #1;
                chk(src_haddr, ea);
                chk(dst_haddr, eb);
                chk({29'h0, src_hsize}, 32'(s));
                chk({29'h0, dst_hsize}, 32'(s));
                chk({28'h0, dst_hprot}, {28'h0, cw[23:21], dcw_pkg::HPROT_DATA});
                apb(1'h0, dcw_pkg::OFS_ATTR, 32'h0);
                chk(rd, {25'h0, cw[23:21], dcw_pkg::HPROT_DATA, 1'h0, 2'(s)});
                chk({31'h0, er}, 32'h0);
                apb(1'h0, dcw_pkg::OFS_DST_ADDR, 32'h0);
                chk(rd, eb);
                apb(1'h0, dcw_pkg::OFS_CONTROL, 32'h0);
                chk(rd, cw);
                chk({28'h0, seen_prot}, {28'h0, cw[23:21], dcw_pkg::HPROT_DATA});
                chk(seen_addr, eb);
            end
        end
        // Count boundaries: none left, and the largest count
        apb(1'h1, dcw_pkg::OFS_REMAIN, 32'h0);
        @(posedge pclk);
        #1;
        chk(dst_haddr, 32'h2000);
        apb(1'h1, dcw_pkg::OFS_REMAIN, 32'h3FF);
        @(posedge pclk);
        #1;
        chk(dst_haddr, 32'h1004);
        chk(src_haddr, 32'h1000);
        apb(1'h1, dcw_pkg::OFS_SRC_ADDR, 32'hFFFF_FFFF);
        chk(src_haddr, 32'h1000);
        apb(1'h0, 12'h020, 32'h0);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        give_verdict();
    end
endmodule : tb
